//--- verification/voltage_peak_and_energy_status_asserts.sv
`include "peak_status_map.svh"

// watches only the top ports; read data is judged one cycle after its take
module voltage_peak_and_energy_status_asserts
  import peak_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire volt_sample_type volt_sample,
  input wire energy_bit30_type energy_bit30,
  input wire power_sign_in_type power_sign,
  input wire logic half_cycle_strobe,
  input wire logic irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic take, rd_peak, rd_stat, rd_sign, rd_smp, rd_peak_q, fresh, has_last;
  logic [23:0] last_peak;
  logic [3:0] ps_q;
  logic [3:0] stable_cnt;
  // read takes per register
  assign take = hsel && hready && htrans[1] && !hwrite && clk_en;
  assign rd_peak = take && haddr == {`HADDR_TOP_ZERO, `IDX_VOLT_PEAK, 2'h0};
  assign rd_stat = take && haddr == {`HADDR_TOP_ZERO, `IDX_STATUS_LOW, 2'h0};
  assign rd_sign = take && haddr == {`HADDR_TOP_ZERO, `IDX_POWER_SIGN, 2'h0};
  assign rd_smp = take && haddr == {`HADDR_TOP_ZERO, `IDX_VOLT_SAMPLE, 2'h0};
  // history of peak reads and sign input stability
  always_ff @(posedge clk_sys) begin
    if (reset && clk_en) begin
      rd_peak_q <= 1'b0;
      fresh <= 1'b1;
      has_last <= 1'b0;
      stable_cnt <= 4'h0;
    end else if (clk_en) begin
      rd_peak_q <= rd_peak;
      if (volt_sample.valid) fresh <= 1'b0;
      if (rd_peak_q) has_last <= 1'b1;
      if (!$stable(power_sign)) stable_cnt <= 4'h0;
      else if (stable_cnt < 4'h8) stable_cnt <= stable_cnt + 4'h1;
    end
  end
  // captured values; not reset, only read when qualified
  always_ff @(posedge clk_sys) begin
    ps_q <= {power_sign.fund_reactive, power_sign.pulse1_sum};
    if (rd_peak_q) last_peak <= hrdata[23:0];
  end

  reset_quiet_a: assert property (
    @(posedge clk_sys) disable iff (1'b0) reset && clk_en |=>
    !irq && !hresp && hrdata == `ZERO_WORD && hreadyout)
    else $error("outputs not quiet after reset");
  peak_top_a: assert property (rd_peak |=> hrdata[31:27] == 5'h00)
    else $error("peak upper bits not zero");
  peak_phase_a: assert property (rd_peak |=>
    (hrdata[23:0] == `PEAK_RESET) ? hrdata[26:24] == `PHASE_RESET
    : $onehot(hrdata[26:24])) else $error("peak phase not one-hot");
  peak_fresh_a: assert property (rd_peak_q && fresh |->
    hrdata == `ZERO_WORD) else $error("peak not zero before samples");
  peak_grow_a: assert property (rd_peak_q && has_last |->
    hrdata[23:0] >= last_peak) else $error("peak value decreased");
  status_rsvd_a: assert property (rd_stat |=>
    !hrdata[2] && hrdata[31:13] == 19'h00000)
    else $error("reserved status bits set");
  sign_pad_a: assert property (rd_sign |=> hrdata[31:7] == '0)
    else $error("sign register padding not zero");
  sample_ext_a: assert property (rd_smp |=>
    hrdata[31:24] == {8{hrdata[23]}}) else $error("sample not sign extended");
  sign_match_a: assert property (rd_sign |=>
    stable_cnt < 4'h2 || hrdata[6:3] == ps_q)
    else $error("sign register differs from inputs");

  cover property (rd_peak_q && hrdata[23:0] != 24'h000000);
  cover property ($rose(irq));
  cover property (rd_sign ##1 hrdata[3]);
endmodule // voltage_peak_and_energy_status_asserts

//--- verification/voltage_peak_and_energy_status_tb_top.sv
`include "peak_status_map.svh"

module voltage_peak_and_energy_status_tb_top
  import peak_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1, hsel = 1'b0;
  logic hwrite = 1'b0, half_cycle_strobe = 1'b0, hready, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h00000000, hwdata = 32'h00000000, hrdata, rd;
  volt_sample_type vs = '0;
  energy_bit30_type eb = '0;
  power_sign_in_type ps = '0;
  int n_mismatch = 0, total_checks = 0;
  // peak steps: phase code, sample, expected magnitude and one-hot phase
  logic [1:0] ph [6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h2, 2'h2};
  logic [23:0] sv [6] = '{24'h000064, 24'hFFFF38, 24'h000096, 24'h0003E8,
    24'h0000C8, 24'h800000};
  logic [23:0] ev [6] = '{24'h000064, 24'h0000C8, 24'h0000C8, 24'h0000C8,
    24'h0000C8, 24'h800000};
  logic [2:0] ep [6] = '{3'h2, 3'h1, 3'h1, 3'h1, 3'h1, 3'h4};
  int bp [4] = '{0, 1, 3, 4};

  assign hready = hreadyout; // single slave drives the bus ready

  initial forever #25 clk_sys = ~clk_sys;

  voltage_peak_and_energy_status i_dut (.clk_sys(clk_sys), .reset(reset),
    .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .volt_sample(vs), .energy_bit30(eb), .power_sign(ps),
    .half_cycle_strobe(half_cycle_strobe), .irq(irq));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({31'h00000000, got}, {31'h00000000, exp}, what);
  endtask

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED %0t bus never ready", $time);
      final_report();
    end
  endtask

  // one single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [15:0] idx,
    input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {14'h0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp,
    input string what);
    xfer(1'b0, idx, 32'h00000000);
    check_word(rd, exp, what);
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rchk(`IDX_VOLT_PEAK, 32'h00000000, "peak reset");
    rchk(`IDX_STATUS_LOW, 32'h00000000, "status reset");
    rchk(16'hE503, 32'h00000000, "unmapped read");
    check_bit(irq, 1'b0, "irq reset");
    $display("test reset done");
    // peak follows larger magnitudes only, phase code 3 ignored
    for (int i = 0; i < 6; i++) begin
      vs <= '{1'b1, ph[i], sv[i]};
      @(posedge clk_sys);
      vs.valid <= 1'b0;
      @(posedge clk_sys);
      rchk(`IDX_VOLT_PEAK, {5'h00, ep[i], ev[i]},
        "peak");
    end
    rchk(`IDX_VOLT_SAMPLE, 32'hFF800000, "sample extend");
    xfer(1'b1, `IDX_VOLT_PEAK, 32'h0000FFFF);
    rchk(`IDX_VOLT_PEAK, 32'h04800000, "peak read-only");
    $display("test peak done");
    // each energy half flag: set, held on zero write, cleared; only the first is also masked
    xfer(1'b1, `IDX_STATUS_ENABLE, 32'h00001FFF);
    rchk(`IDX_STATUS_ENABLE, 32'h00001FFB, "enable bit2");
    for (int g = 0; g < 4; g++) begin
      eb <= eb ^ (12'h001 << ((3 - g) * 3 + g % 3));
      repeat (2) @(posedge clk_sys);
      check_bit(irq, 1'b1, "irq on energy");
      rchk(`IDX_STATUS_LOW, 32'h1 << bp[g], "flag");
      if (g == 0) begin
        xfer(1'b1, `IDX_STATUS_ENABLE, 32'h00000000);
        repeat (2) @(posedge clk_sys);
        check_bit(irq, 1'b0, "irq masked");
        xfer(1'b1, `IDX_STATUS_ENABLE, 32'h00001FFF);
        repeat (2) @(posedge clk_sys);
        check_bit(irq, 1'b1, "irq unmasked");
      end
      xfer(1'b1, `IDX_STATUS_LOW, 32'h00000000);
      rchk(`IDX_STATUS_LOW, 32'h1 << bp[g], "zero write");
      xfer(1'b1, g[0] ? `IDX_STATUS_CLEAR : `IDX_STATUS_LOW, 32'h1 << bp[g]);
      rchk(`IDX_STATUS_LOW, 32'h00000000, "flag cleared");
      check_bit(irq, 1'b0, "irq cleared");
    end
    $display("test energy done");
    // sign changes on total source, sum and fundamental reactive
    ps.total_active <= 3'h5;
    repeat (3) @(posedge clk_sys);
    rchk(`IDX_POWER_SIGN, 32'h00000005, "active sign");
    rchk(`IDX_STATUS_LOW, 32'h00000140, "active flags");
    xfer(1'b1, `IDX_STATUS_LOW, 32'h00001FFF);
    ps.pulse1_sum <= 1'b1;
    ps.fund_reactive <= 3'h2;
    repeat (3) @(posedge clk_sys);
    rchk(`IDX_POWER_SIGN, 32'h0000002D, "sum reactive sign");
    rchk(`IDX_STATUS_LOW, 32'h00000A00, "sum reactive flags");
    // switching source may flag; let it settle before clearing
    xfer(1'b1, `IDX_ACCUM_MODE, 32'h00000040);
    repeat (3) @(posedge clk_sys);
    xfer(1'b1, `IDX_STATUS_LOW, 32'h00001FFF);
    ps.fund_active <= 3'h3;
    ps.total_active <= 3'h0;
    repeat (3) @(posedge clk_sys);
    rchk(`IDX_POWER_SIGN, 32'h0000002B, "fund sign");
    rchk(`IDX_STATUS_LOW, 32'h000000C0, "fund flags");
    xfer(1'b1, `IDX_STATUS_LOW, 32'h00001FFF);
    $display("test sign done");
    // line-cycle accumulation over three half cycles
    xfer(1'b1, `IDX_HALF_CYCLE, 32'h00000003);
    xfer(1'b1, `IDX_ACCUM_MODE, 32'h00000042);
    repeat (3) @(posedge clk_sys);
    for (int i = 0; i < 3; i++) begin
      half_cycle_strobe <= 1'b1;
      @(posedge clk_sys);
      half_cycle_strobe <= 1'b0;
      repeat (3) @(posedge clk_sys);
      if (i == 1) rchk(`IDX_STATUS_LOW, 32'h00000000, "line early");
    end
    rchk(`IDX_STATUS_LOW, 32'h00000020, "line done");
    $display("test line cycle done");
    // reset in mid-run clears the peak and the interrupt
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rchk(`IDX_VOLT_PEAK, 32'h00000000, "peak after reset");
    check_bit(irq, 1'b0, "irq after reset");
    // a larger sample while the clock enable is low is not taken
    clk_en <= 1'b0;
    vs <= '{1'b1, 2'h1, 24'h000100};
    repeat (2) @(posedge clk_sys);
    vs.valid <= 1'b0;
    clk_en <= 1'b1;
    @(posedge clk_sys);
    rchk(`IDX_VOLT_PEAK, 32'h00000000, "peak frozen");
    $display("test mid reset done");
    final_report();
  end
endmodule // voltage_peak_and_energy_status_tb_top

bind voltage_peak_and_energy_status voltage_peak_and_energy_status_asserts
  i_chk (.clk_sys, .reset, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .volt_sample, .energy_bit30,
  .power_sign, .half_cycle_strobe, .irq);

//--- verilog/peak_status_map.svh
`ifndef PEAK_STATUS_MAP_SVH
`define PEAK_STATUS_MAP_SVH

// register indices; byte address is four times the index
`define IDX_VOLT_PEAK 16'hE501
`define IDX_STATUS_LOW 16'hE502
`define IDX_STATUS_CLEAR 16'hE510
`define IDX_STATUS_ENABLE 16'hE511
`define IDX_ACCUM_MODE 16'hE512
`define IDX_POWER_SIGN 16'hE513
`define IDX_HALF_CYCLE 16'hE514
`define IDX_VOLT_SAMPLE 16'hE515

// status bit positions
`define ST_TOTAL_ACTIVE_HALF 0
`define ST_FUND_ACTIVE_HALF 1
`define ST_RESERVED_2 2
`define ST_FUND_REACTIVE_HALF 3
`define ST_APPARENT_HALF 4
`define ST_LINE_CYCLE_DONE 5
`define ST_ACTIVE_SIGN_LO 6
`define ST_SUM1_SIGN 9
`define ST_REACTIVE_SIGN_LO 10
`define ST_WIDTH 13
`define ST_DEFINED_MASK 13'h1FFB
`define ST_RESET 13'h0000

// accumulation mode bits
`define ACC_LINE_MODE 1
`define ACC_SIGN_SELECT 6
`define ACC_WIDTH 8
`define ACC_RESET 8'h00

// power sign register layout
`define SIGN_ACTIVE_LO 0
`define SIGN_SUM1 3
`define SIGN_REACTIVE_LO 4
`define SIGN_WIDTH 7

// peak register layout
`define PEAK_VALUE_HI 23
`define PEAK_PHASE_LO 24
`define PEAK_RESET 24'h000000
`define PHASE_RESET 3'h0
`define PHASE_ONEHOT_A 3'h1

// misc widths and values
`define HALF_CYCLE_WIDTH 16
`define HALF_CYCLE_RESET 16'h0000
`define HALF_CYCLE_ONE 16'h0001
`define ZERO_WORD 32'h00000000
`define BYTE_LANE_ZERO 2'h0
`define HADDR_TOP_ZERO 14'h0000

`endif

//--- verilog/peak_status_pkg.sv
package peak_status_pkg;

  // one voltage sample from the measurement path
  typedef struct packed {
    logic valid;
    logic [1:0] phase;
    logic signed [23:0] value;
  } volt_sample_type;

  // bit 30 of every phase energy accumulator
  typedef struct packed {
    logic [2:0] total_active;
    logic [2:0] fund_active;
    logic [2:0] fund_reactive;
    logic [2:0] apparent;
  } energy_bit30_type;

  // present signs of the powers, 1 means negative
  typedef struct packed {
    logic [2:0] total_active;
    logic [2:0] fund_active;
    logic pulse1_sum;
    logic [2:0] fund_reactive;
  } power_sign_in_type;

  // line-cycle accumulation sequencer
  typedef enum logic [1:0] {
    LINE_IDLE = 2'b00,
    LINE_COUNT = 2'b01,
    LINE_DONE = 2'b10
  } line_state_type;

  // 24-bit unsigned register sent as 32 bits, zero padded
  function automatic logic [31:0] zero_pad24(input logic [23:0] v);
    return {8'h00, v};
  endfunction

  // 24-bit signed register sent as 32 bits, sign extended
  function automatic logic [31:0] sign_ext24(input logic [23:0] v);
    return {{8{v[23]}}, v};
  endfunction

  // 10-bit unsigned register sent as 16 bits, zero padded
  function automatic logic [15:0] zero_pad10(input logic [9:0] v);
    return {6'h00, v};
  endfunction

endpackage

//--- verilog/peak_tracker.sv
`include "peak_status_map.svh"

// keeps the largest voltage magnitude and its source phase
module peak_tracker
  import peak_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire volt_sample_type sample,
  output logic [23:0] peak_value,
  output logic [2:0] peak_phase
);

  logic [23:0] magnitude;
  logic phase_ok;

  // -2^23 maps to 2^23, which still fits 24 unsigned bits
  assign magnitude = sample.value[23] ? 24'(-sample.value)
                                      : 24'(sample.value);
  // code 3 names no phase and is ignored
  assign phase_ok = (sample.phase != 2'h3);

  // value and phase move together on a strictly larger sample
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      peak_value <= `PEAK_RESET;
      peak_phase <= `PHASE_RESET;
    end else if (clk_en && sample.valid && phase_ok
                 && magnitude > peak_value) begin
      peak_value <= magnitude;
      peak_phase <= `PHASE_ONEHOT_A << sample.phase;
    end
  end

endmodule // peak_tracker

//--- verilog/sign_tracker.sv
`include "peak_status_map.svh"

// remembers each sign and pulses when one flips
module sign_tracker
  import peak_status_pkg::*;
#(
  parameter int WIDTH = `SIGN_WIDTH
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] sign_in,
  output logic [WIDTH-1:0] sign_reg,
  output logic [WIDTH-1:0] change_pulse
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // pulse lasts one enabled cycle, alongside the new sign
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          sign_reg[i] <= 1'b0;
          change_pulse[i] <= 1'b0;
        end else if (clk_en) begin
          sign_reg[i] <= sign_in[i];
          change_pulse[i] <= sign_in[i] ^ sign_reg[i];
        end
      end
    end
  endgenerate

endmodule // sign_tracker

//--- verilog/voltage_peak_and_energy_status.sv
// Local design decision: register access over AHB-Lite.
`include "peak_status_map.svh"

module voltage_peak_and_energy_status
  import peak_status_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // measurement path, same clock
  input wire volt_sample_type volt_sample,
  input wire energy_bit30_type energy_bit30,
  input wire power_sign_in_type power_sign,
  input wire logic half_cycle_strobe,
  // interrupt
  output logic irq
);

  logic [`ST_WIDTH-1:0] status_reg;
  logic [`ST_WIDTH-1:0] status_next;
  logic [`ST_WIDTH-1:0] status_set;
  logic [`ST_WIDTH-1:0] status_clear;
  logic [`ST_WIDTH-1:0] enable_reg;
  logic [`ACC_WIDTH-1:0] accumulation_mode_reg;
  logic [`HALF_CYCLE_WIDTH-1:0] half_cycle_count_setting_reg;
  logic [`HALF_CYCLE_WIDTH-1:0] half_cycle_count_reg;
  line_state_type line_state_reg;
  line_state_type line_state_next;
  logic line_cycle_accum_done;
  logic [11:0] bit30_prev_reg;
  logic [11:0] bit30_change;
  logic [23:0] volt_peak_value;
  logic [2:0] volt_peak_source_phase;
  logic [23:0] last_sample_reg;
  logic [`SIGN_WIDTH-1:0] sign_source;
  logic [`SIGN_WIDTH-1:0] power_sign_register;
  logic [`SIGN_WIDTH-1:0] sign_change;
  logic active_sign_source_select;
  logic access_ok;
  logic [15:0] access_index;
  logic wr_pending_reg;
  logic [15:0] wr_index_reg;
  logic [31:0] read_word;

  // peak capture
  // the raw sample is kept too, so software can see the last value

  peak_tracker u_peak (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .sample(volt_sample),
    .peak_value(volt_peak_value),
    .peak_phase(volt_peak_source_phase)
  );

  // raw sample kept for software, shown sign extended
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      last_sample_reg <= `PEAK_RESET;
    end else if (clk_en && volt_sample.valid) begin
      last_sample_reg <= volt_sample.value;
    end
  end

  // energy half-full watch
  // only a change of bit 30 matters, never its level

  // previous bit 30 of every accumulator; a 1 after reset counts
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bit30_prev_reg <= 12'h000;
    end else if (clk_en) begin
      bit30_prev_reg <= energy_bit30;
    end
  end

  // one-cycle pulse per flip; the status register makes it sticky
  assign bit30_change = energy_bit30 ^ bit30_prev_reg;

  // sign tracking
  // flags trail the sign register by one enabled cycle

  assign active_sign_source_select =
    accumulation_mode_reg[`ACC_SIGN_SELECT];

  // active sign path picks total or fundamental power
  assign sign_source = {
    power_sign.fund_reactive,
    power_sign.pulse1_sum,
    active_sign_source_select ? power_sign.fund_active
                              : power_sign.total_active
  };

  sign_tracker #(
    .WIDTH(`SIGN_WIDTH)
  ) u_signs (
    .clk_sys(clk_sys),
    .reset(reset),
    .clk_en(clk_en),
    .sign_in(sign_source),
    .sign_reg(power_sign_register),
    .change_pulse(sign_change)
  );

  // line-cycle accumulation
  // strobes during the restart cycle are not counted, a known limit

  // a setting of zero never starts a count, avoiding a flag every cycle
  always_comb begin
    line_state_next = line_state_reg;
    case (line_state_reg)
      LINE_IDLE: begin
        if (accumulation_mode_reg[`ACC_LINE_MODE]
            && half_cycle_count_setting_reg != `HALF_CYCLE_RESET) begin
          line_state_next = LINE_COUNT;
        end
      end
      LINE_COUNT: begin
        if (!accumulation_mode_reg[`ACC_LINE_MODE]) begin
          line_state_next = LINE_IDLE;
        end else if (half_cycle_strobe
                     && half_cycle_count_reg + `HALF_CYCLE_ONE
                        >= half_cycle_count_setting_reg) begin
          line_state_next = LINE_DONE;
        end
      end
      LINE_DONE: begin
        line_state_next = LINE_IDLE;
      end
      default: begin
        line_state_next = LINE_IDLE;
      end
    endcase
  end

  // sequencer state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      line_state_reg <= LINE_IDLE;
    end else if (clk_en) begin
      line_state_reg <= line_state_next;
    end
  end

  // half cycles seen in the running integration
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      half_cycle_count_reg <= `HALF_CYCLE_RESET;
    end else if (clk_en) begin
      if (line_state_reg != LINE_COUNT) begin
        half_cycle_count_reg <= `HALF_CYCLE_RESET;
      end else if (half_cycle_strobe) begin
        half_cycle_count_reg <= half_cycle_count_reg + `HALF_CYCLE_ONE;
      end
    end
  end

  // done lasts one cycle, the status bit holds it
  assign line_cycle_accum_done = (line_state_reg == LINE_DONE);

  // status flags
  // sticky flags; only the defined bits can ever be set

  // events of this cycle, one bit each
  always_comb begin
    status_set = `ST_RESET;
    status_set[`ST_TOTAL_ACTIVE_HALF] =
      |bit30_change[11:9];
    status_set[`ST_FUND_ACTIVE_HALF] =
      |bit30_change[8:6];
    status_set[`ST_FUND_REACTIVE_HALF] =
      |bit30_change[5:3];
    status_set[`ST_APPARENT_HALF] =
      |bit30_change[2:0];
    status_set[`ST_LINE_CYCLE_DONE] = line_cycle_accum_done;
    status_set[`ST_ACTIVE_SIGN_LO +: 3] =
      sign_change[`SIGN_ACTIVE_LO +: 3];
    status_set[`ST_SUM1_SIGN] = sign_change[`SIGN_SUM1];
    status_set[`ST_REACTIVE_SIGN_LO +: 3] =
      sign_change[`SIGN_REACTIVE_LO +: 3];
  end

  // write-one-to-clear through the status or the clear register
  always_comb begin
    status_clear = `ST_RESET;
    if (wr_pending_reg
        && (wr_index_reg == `IDX_STATUS_LOW
            || wr_index_reg == `IDX_STATUS_CLEAR)) begin
      status_clear = hwdata[`ST_WIDTH-1:0];
    end
  end

  // a set in the same cycle as its clear wins
  assign status_next = ((status_reg & ~status_clear) | status_set)
                       & `ST_DEFINED_MASK;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      status_reg <= `ST_RESET;
    end else if (clk_en) begin
      status_reg <= status_next;
    end
  end

  // level interrupt from enabled flags
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(status_next & enable_reg);
    end
  end

  // ahb-lite slave
  // no wait states, so hreadyout never drops

  // transfers of any hsize at an aligned index address only
  assign access_ok = hsel && hready && htrans[1]
                     && haddr[1:0] == `BYTE_LANE_ZERO
                     && haddr[31:18] == `HADDR_TOP_ZERO;
  assign access_index = haddr[17:2];

  // write address held for the data phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_pending_reg <= 1'b0;
      wr_index_reg <= 16'h0000;
    end else if (clk_en) begin
      wr_pending_reg <= access_ok && hwrite;
      wr_index_reg <= access_index;
    end
  end

  // software-written control registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      enable_reg <= `ST_RESET;
      accumulation_mode_reg <= `ACC_RESET;
      half_cycle_count_setting_reg <= `HALF_CYCLE_RESET;
    end else if (clk_en && wr_pending_reg) begin
      case (wr_index_reg)
        `IDX_STATUS_ENABLE: begin
          enable_reg <= hwdata[`ST_WIDTH-1:0] & `ST_DEFINED_MASK;
        end
        `IDX_ACCUM_MODE: begin
          accumulation_mode_reg <= hwdata[`ACC_WIDTH-1:0];
        end
        `IDX_HALF_CYCLE: begin
          half_cycle_count_setting_reg <=
            hwdata[`HALF_CYCLE_WIDTH-1:0];
        end
        default: begin
          enable_reg <= enable_reg;
        end
      endcase
    end
  end

  // read data formed in the address phase; unmapped reads zero
  always_comb begin
    read_word = `ZERO_WORD;
    case (access_index)
      `IDX_VOLT_PEAK: begin
        read_word = zero_pad24(volt_peak_value);
        read_word[`PEAK_PHASE_LO +: 3] = volt_peak_source_phase;
        // bits above the phase field stay zero
      end
      `IDX_STATUS_LOW: begin
        read_word = {19'h00000, status_reg};
      end
      `IDX_STATUS_ENABLE: begin
        read_word = {19'h00000, enable_reg};
      end
      `IDX_ACCUM_MODE: begin
        read_word = {24'h000000, accumulation_mode_reg};
      end
      `IDX_POWER_SIGN: begin
        // signs as a 10-bit field padded to 16 bits
        read_word = {16'h0000,
                     zero_pad10({3'h0, power_sign_register})};
      end
      `IDX_HALF_CYCLE: begin
        read_word = {16'h0000, half_cycle_count_setting_reg};
      end
      `IDX_VOLT_SAMPLE: begin
        read_word = sign_ext24(last_sample_reg);
      end
      default: begin
        read_word = `ZERO_WORD;
      end
    endcase
  end

  // registered read data; valid throughout the data phase
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hrdata <= `ZERO_WORD;
    end else if (clk_en) begin
      if (access_ok && !hwrite) begin
        hrdata <= read_word;
      end
    end
  end

  // zero wait states, always okay; hsize is not checked
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule // voltage_peak_and_energy_status
